// >>> rtl/cdtt_defs.svh
// Purpose: constants for the core debug trigger and trace block
// Assumes: core clock 10 MHz
// Notes: serial command word is 4-bit opcode, 4-bit index, then 32-bit data, MSB first
`ifndef CDTT_DEFS_SVH
`define CDTT_DEFS_SVH
`define CDTT_NREG 9
`define CDTT_IDX_ADDR 4'h0
`define CDTT_IDX_AMSK 4'h1
`define CDTT_IDX_DATA 4'h2
`define CDTT_IDX_DMSK 4'h3
`define CDTT_IDX_PC0 4'h4
`define CDTT_IDX_PMSK 4'h8
`define CDTT_IDX_CTRL 4'h9
`define CDTT_CMD_BITS 6'd40
`define CDTT_OP_WR 4'h1
`define CDTT_OP_RD 4'h2
`define CDTT_CTL_EN 0
`define CDTT_CTL_TWO 1
`define CDTT_CTL_HALT 2
`define CDTT_CTL_L1A 3
`define CDTT_CTL_L1D 4
`define CDTT_CTL_L1P 5
`define CDTT_CTL_L2A 6
`define CDTT_CTL_L2D 7
`define CDTT_CTL_L2P 8
`define CDTT_PST_RUN 4'h0
`define CDTT_PST_BRANCH 4'h5
`define CDTT_PST_DATA 4'h8
`define CDTT_PST_HALT 4'hF
`define CDTT_FIFO_DEPTH 8
`endif

// >>> rtl/cdtt_pkg.sv
// Purpose: types for the core debug trigger and trace block
// Assumes: nothing
// Notes: none
package cdtt_pkg;
   typedef enum logic [1:0] {
      CDTT_TRG_IDLE = 2'b00,
      CDTT_TRG_ARMED = 2'b01,
      CDTT_TRG_FIRED = 2'b10
   } cdtt_trg_t;
   typedef enum logic [1:0] {
      CDTT_TR_IDLE = 2'b00,
      CDTT_TR_SEND = 2'b01
   } cdtt_tr_t;
endpackage

// >>> rtl/cdtt_fifo.sv
// Purpose: small first-in first-out buffer for trace words
// Assumes: one clock
// Notes: output data comes from the storage array
`timescale 1ns/1ns
`default_nettype none
module cdtt_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic ce_i,
   // Write side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // Read side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wp_q;
   logic [AW-1:0] rp_q;
   logic [AW:0] cnt_q;
   logic wr;
   logic rd;

   assign in_ready_o = (cnt_q != DEPTH[AW:0]);
   assign out_valid_o = (cnt_q != '0);
   assign wr = in_valid_i && in_ready_o && ce_i;
   assign rd = out_valid_o && out_ready_i && ce_i;
   assign out_data_o = mem_q[rp_q];

   always_ff @(posedge clk_i) begin
      if (wr) begin
         mem_q[wp_q] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end else begin
         if (wr) begin
            wp_q <= wp_q + 1'b1;
         end
         if (rd) begin
            rp_q <= rp_q + 1'b1;
         end
         if (wr && !rd) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (rd && !wr) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// >>> rtl/cdtt_top.sv
// Purpose: breakpoint triggers, trace port and serial debug access
// Assumes: serial channel on its own clock, core on core_clk_i
// Notes: serial frame is 40 bits: opcode, index, 32 data bits
`timescale 1ns/1ns
`default_nettype none
`include "cdtt_defs.svh"
module cdtt_top
   import cdtt_pkg::*;
(
   // Core clock and reset
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic ce_i,
   // Serial debug channel
   input wire logic debug_serial_clock,
   input wire logic debug_serial_in_i,
   output logic debug_serial_out_o,
   // Supervisor register port
   input wire logic sup_wr_i,
   input wire logic sup_rd_i,
   input wire logic [3:0] sup_idx_i,
   input wire logic [31:0] sup_wdata_i,
   output logic [31:0] sup_rdata_o,
   // Core observation
   input wire logic bus_valid_i,
   input wire logic [31:0] bus_addr_i,
   input wire logic [31:0] bus_data_i,
   input wire logic pc_valid_i,
   input wire logic [31:0] pc_i,
   input wire logic core_halted_i,
   input wire logic branch_i,
   input wire logic [31:0] branch_tgt_i,
   input wire logic crit_irq_i,
   // Core control
   output logic halt_req_o,
   output logic dbg_irq_o,
   output logic crit_irq_o,
   // Trace port
   output logic [3:0] processor_status_out,
   output logic [3:0] trace_data_out,
   output logic status_clock_out,
   output logic all_status_and_out
);
   // Register file
   logic [31:0] bkpt_q [`CDTT_NREG];
   logic [8:0] ctrl_q;
   logic [31:0] rd_mux;

   // Serial side, link clock domain
   logic [39:0] sh_q;
   logic [5:0] bit_q;
   logic [39:0] cmd_q;
   logic cmd_tgl_q;
   logic [31:0] tx_q;
   // Core side crossing
   logic [2:0] tgl_sync_q;
   logic [39:0] cmd_core_q;
   logic cmd_stb;
   logic [31:0] ser_rdata_q;
   logic ser_wr;
   logic ser_rd;
   logic [3:0] ser_idx;

   always_ff @(posedge debug_serial_clock or negedge rstn_i) begin
      if (!rstn_i) begin
         sh_q <= '0;
         bit_q <= '0;
         cmd_q <= '0;
         cmd_tgl_q <= 1'b0;
         tx_q <= '0;
      end else begin
         sh_q <= {sh_q[38:0], debug_serial_in_i};
         if (bit_q == `CDTT_CMD_BITS - 6'd1) begin
            bit_q <= '0;
            cmd_q <= {sh_q[38:0], debug_serial_in_i};
            cmd_tgl_q <= ~cmd_tgl_q;
            tx_q <= ser_rdata_q;
         end else begin
            bit_q <= bit_q + 6'd1;
            tx_q <= {tx_q[30:0], 1'b0};
         end
      end
   end
   assign debug_serial_out_o = tx_q[31];

   // Toggle crossing: command word is stable when toggle arrives
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tgl_sync_q <= '0;
         cmd_core_q <= '0;
      end else if (ce_i) begin
         tgl_sync_q <= {tgl_sync_q[1:0], cmd_tgl_q};
         if (tgl_sync_q[2] != tgl_sync_q[1]) begin
            cmd_core_q <= cmd_q;
         end
      end
   end
   logic cmd_pend_q;
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cmd_pend_q <= 1'b0;
      end else if (ce_i) begin
         cmd_pend_q <= (tgl_sync_q[2] != tgl_sync_q[1]);
      end
   end
   assign cmd_stb = cmd_pend_q;
   assign ser_idx = cmd_core_q[35:32];
   assign ser_wr = cmd_stb && (cmd_core_q[39:36] == `CDTT_OP_WR);
   assign ser_rd = cmd_stb && (cmd_core_q[39:36] == `CDTT_OP_RD);

   function automatic logic [31:0] rd_reg(input logic [3:0] idx);
      logic [31:0] v;
      v = '0;
      if (idx < `CDTT_IDX_CTRL) begin
         v = bkpt_q[idx];
      end else if (idx == `CDTT_IDX_CTRL) begin
         v = {23'h0, ctrl_q};
      end
      return v;
   endfunction

   assign rd_mux = rd_reg(sup_idx_i);

   // Supervisor write wins when both paths write in one cycle
   genvar gi;
   generate
      for (gi = 0; gi < `CDTT_NREG; gi++) begin : g_reg
         always_ff @(posedge core_clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
               bkpt_q[gi] <= '0;
            end else if (ce_i) begin
               if (sup_wr_i && sup_idx_i == 4'(gi)) begin
                  bkpt_q[gi] <= sup_wdata_i;
               end else if (ser_wr && ser_idx == 4'(gi)) begin
                  bkpt_q[gi] <= cmd_core_q[31:0];
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ctrl_q <= '0;
         sup_rdata_o <= '0;
         ser_rdata_q <= '0;
      end else if (ce_i) begin
         if (sup_wr_i && sup_idx_i == `CDTT_IDX_CTRL) begin
            ctrl_q <= sup_wdata_i[8:0];
         end else if (ser_wr && ser_idx == `CDTT_IDX_CTRL) begin
            ctrl_q <= cmd_core_q[8:0];
         end
         if (sup_rd_i) begin
            sup_rdata_o <= rd_mux;
         end
         if (ser_rd) begin
            ser_rdata_q <= rd_reg(ser_idx);
         end
      end
   end

   // Comparators: mask bit one excludes that bit
   logic hit_a;
   logic hit_d;
   logic [3:0] hit_pc;
   logic hit_p;
   assign hit_a = bus_valid_i && (((bus_addr_i ^ bkpt_q[`CDTT_IDX_ADDR])
      & ~bkpt_q[`CDTT_IDX_AMSK]) == '0);
   assign hit_d = bus_valid_i && (((bus_data_i ^ bkpt_q[`CDTT_IDX_DATA])
      & ~bkpt_q[`CDTT_IDX_DMSK]) == '0);
   generate
      for (gi = 0; gi < 4; gi++) begin : g_pc
         assign hit_pc[gi] = pc_valid_i &&
            (((pc_i ^ bkpt_q[`CDTT_IDX_PC0 + gi])
            & ~bkpt_q[`CDTT_IDX_PMSK]) == '0);
      end
   endgenerate
   assign hit_p = |hit_pc;

   // Level condition: all selected comparators must match
   function automatic logic lvl(input logic [2:0] sel, input logic a,
      input logic d, input logic p);
      lvl = (sel != 3'b000) && (!sel[0] || a) && (!sel[1] || d) &&
         (!sel[2] || p);
   endfunction

   logic l1;
   logic l2;
   assign l1 = lvl(ctrl_q[`CDTT_CTL_L1P:`CDTT_CTL_L1A], hit_a, hit_d,
      hit_p);
   assign l2 = lvl(ctrl_q[`CDTT_CTL_L2P:`CDTT_CTL_L2A], hit_a, hit_d,
      hit_p);

   cdtt_trg_t trg_q;
   logic fire;
   assign fire = ctrl_q[`CDTT_CTL_EN] && trg_q != CDTT_TRG_FIRED &&
      ((!ctrl_q[`CDTT_CTL_TWO] && l1) ||
      (ctrl_q[`CDTT_CTL_TWO] && trg_q == CDTT_TRG_ARMED && l2));

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         trg_q <= CDTT_TRG_IDLE;
      end else if (ce_i) begin
         if (!ctrl_q[`CDTT_CTL_EN]) begin
            trg_q <= CDTT_TRG_IDLE;
         end else begin
            case (trg_q)
               CDTT_TRG_IDLE: begin
                  if (fire) begin
                     trg_q <= CDTT_TRG_FIRED;
                  end else if (ctrl_q[`CDTT_CTL_TWO] && l1) begin
                     trg_q <= CDTT_TRG_ARMED;
                  end
               end
               CDTT_TRG_ARMED: begin
                  if (fire) begin
                     trg_q <= CDTT_TRG_FIRED;
                  end
               end
               default: begin
                  trg_q <= CDTT_TRG_FIRED;
               end
            endcase
         end
      end
   end

   // Action outputs; disabling the trigger releases them
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         halt_req_o <= 1'b0;
         dbg_irq_o <= 1'b0;
      end else if (ce_i) begin
         if (fire) begin
            halt_req_o <= ctrl_q[`CDTT_CTL_HALT];
            dbg_irq_o <= !ctrl_q[`CDTT_CTL_HALT];
         end else if (!ctrl_q[`CDTT_CTL_EN]) begin
            halt_req_o <= 1'b0;
            dbg_irq_o <= 1'b0;
         end
      end
   end

   // Critical interrupts bypass debug interrupt masking
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         crit_irq_o <= 1'b0;
      end else if (ce_i) begin
         crit_irq_o <= crit_irq_i;
      end
   end

   // Trace: branch targets through FIFO, sent as 8 nibbles
   logic fifo_v;
   logic fifo_rdy;
   logic [31:0] fifo_d;
   logic take;
   cdtt_tr_t tr_q;
   logic [2:0] nib_q;
   logic [31:0] tw_q;
   assign take = (tr_q == CDTT_TR_IDLE) && !core_halted_i;

   cdtt_fifo #(.WIDTH(32), .DEPTH(`CDTT_FIFO_DEPTH)) u_fifo (
      .clk_i(core_clk_i),
      .rstn_i(rstn_i),
      .ce_i(ce_i),
      .in_valid_i(branch_i),
      .in_ready_o(),
      .in_data_i(branch_tgt_i),
      .out_valid_o(fifo_v),
      .out_ready_i(take),
      .out_data_o(fifo_d)
   );

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tr_q <= CDTT_TR_IDLE;
         nib_q <= '0;
         tw_q <= '0;
         processor_status_out <= `CDTT_PST_RUN;
         trace_data_out <= '0;
      end else if (ce_i) begin
         case (tr_q)
            CDTT_TR_IDLE: begin
               trace_data_out <= '0;
               if (core_halted_i) begin
                  processor_status_out <= `CDTT_PST_HALT;
               end else if (fifo_v) begin
                  processor_status_out <= `CDTT_PST_BRANCH;
                  tw_q <= fifo_d;
                  nib_q <= '0;
                  tr_q <= CDTT_TR_SEND;
               end else begin
                  processor_status_out <= `CDTT_PST_RUN;
               end
            end
            CDTT_TR_SEND: begin
               processor_status_out <= `CDTT_PST_DATA;
               trace_data_out <= tw_q[3:0];
               tw_q <= {4'h0, tw_q[31:4]};
               nib_q <= nib_q + 3'd1;
               if (nib_q == 3'd7) begin
                  tr_q <= CDTT_TR_IDLE;
               end
            end
            default: begin
               tr_q <= CDTT_TR_IDLE;
            end
         endcase
      end
   end

   assign status_clock_out = core_clk_i;
   assign all_status_and_out = &processor_status_out;

   // Assertions
   sequence arm_s;
      ctrl_q[`CDTT_CTL_EN] && ctrl_q[`CDTT_CTL_TWO] && trg_q == CDTT_TRG_ARMED;
   endsequence
   sequence lvl2_s;
      ce_i && l2;
   endsequence
   trig_two_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      arm_s ##0 lvl2_s |=> trg_q == CDTT_TRG_FIRED)
      else $error("two-level trigger did not fire");
   trig_skip_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      ce_i && ctrl_q[`CDTT_CTL_TWO] && trg_q == CDTT_TRG_IDLE && l2 && !l1
      |=> trg_q == CDTT_TRG_IDLE)
      else $error("level two fired without arming");
   halt_act_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      ce_i && fire && ctrl_q[`CDTT_CTL_HALT] |=> halt_req_o && !dbg_irq_o)
      else $error("halt action missing");
   irq_act_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      ce_i && fire && !ctrl_q[`CDTT_CTL_HALT] |=> dbg_irq_o && !halt_req_o)
      else $error("debug interrupt action missing");
   crit_pass_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      ce_i |=> crit_irq_o == $past(crit_irq_i))
      else $error("critical interrupt blocked");
   all_and_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      all_status_and_out == (processor_status_out == 4'hF))
      else $error("combined status wrong");
   halt_pst_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      ce_i && core_halted_i && tr_q == CDTT_TR_IDLE
      |=> processor_status_out == `CDTT_PST_HALT)
      else $error("halt status not shown");
   sup_wr_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      ce_i && sup_wr_i && sup_idx_i == `CDTT_IDX_ADDR
      |=> bkpt_q[`CDTT_IDX_ADDR] == $past(sup_wdata_i))
      else $error("supervisor write lost");
   mask_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      bus_valid_i && bkpt_q[`CDTT_IDX_AMSK] == 32'hFFFFFFFF |-> hit_a)
      else $error("full mask did not match");
endmodule
`default_nettype wire

// >>> dv/cdtt_dbg_tool.sv
// Purpose: debugger tool model on the serial debug channel
// Assumes: 48 ns serial clock that stands still between frames
// Notes: read data leaves in the second frame after a read
`timescale 1ns/1ns
`default_nettype none
module cdtt_dbg_tool (
   // Serial channel
   output logic debug_serial_clock,
   output logic debug_serial_in_o,
   input wire logic debug_serial_out_i
);
   // One edge during reset so the bit counter starts clean
   initial begin
      debug_serial_clock = 1'b0;
      debug_serial_in_o = 1'b0;
      #317 debug_serial_clock = 1'b1;
      #24 debug_serial_clock = 1'b0;
   end
   // One 40-bit frame, MSB first; returns the first 32 bits seen
   task automatic frame(input logic [39:0] cmd, output logic [31:0] rx);
      rx = 32'h0;
      for (int i = 39; i >= 0; i--) begin
         debug_serial_in_o = cmd[i];
         #24;
         if (i >= 8) rx = {rx[30:0], debug_serial_out_i};
         debug_serial_clock = 1'b1;
         #24;
         debug_serial_clock = 1'b0;
      end
      // Released line never keeps showing the last bit
      debug_serial_in_o = ~debug_serial_in_o;
      #900;
   endtask
endmodule
`default_nettype wire

// >>> dv/test_core_debug_trigger_trace.sv
// Purpose: self-checking bench for the debug trigger and trace block
// Assumes: 10 MHz core clock, inputs driven on the falling edge
// Notes: serial traffic comes from the debugger tool model
`timescale 1ns/1ns
`default_nettype none
`include "cdtt_defs.svh"
module test_core_debug_trigger_trace;
   typedef struct packed {
      logic [3:0] idx;
      logic [31:0] wd;
      logic [31:0] rd;
   } cdtt_row_t;
   logic core_clk_i = 1'b0, rstn_i = 1'b0, ce_i = 1'b1;
   logic sup_wr_i = 1'b0, sup_rd_i = 1'b0;
   logic [3:0] sup_idx_i = 4'h0;
   logic [31:0] sup_wdata_i = 32'h0, bus_addr_i = 32'h0, bus_data_i = 32'h0;
   logic [31:0] pc_i = 32'h0, branch_tgt_i = 32'h0, sup_rdata_o;
   logic bus_valid_i = 1'b0, pc_valid_i = 1'b0, core_halted_i = 1'b0;
   logic branch_i = 1'b0, crit_irq_i = 1'b0;
   logic ser_clk, ser_in, ser_out, halt_req_o, dbg_irq_o, crit_irq_o;
   logic status_clock_out, all_status_and_out;
   logic [3:0] processor_status_out, trace_data_out;
   int failures = 0, checks = 0, cycles = 0;
   cdtt_row_t rows [12] = '{
      '{4'h0, 32'hA5A5_0000, 32'hA5A5_0000}, '{4'h1, 32'h0000_FFFF, 32'h0000_FFFF},
      '{4'h2, 32'h5A5A_1234, 32'h5A5A_1234}, '{4'h3, 32'hFFFF_0000, 32'hFFFF_0000},
      '{4'h4, 32'h0000_0100, 32'h0000_0100}, '{4'h5, 32'h8000_0001, 32'h8000_0001},
      '{4'h6, 32'h7FFF_FFFE, 32'h7FFF_FFFE}, '{4'h7, 32'hFFFF_FFFF, 32'hFFFF_FFFF},
      '{4'h8, 32'h0000_0000, 32'h0000_0000}, '{4'h9, 32'h0000_01FE, 32'h0000_01FE},
      '{4'hA, 32'h1234_5678, 32'h0000_0000}, '{4'hF, 32'hFFFF_FFFF, 32'h0000_0000}};

   cdtt_top cdtt_top_i (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .ce_i(ce_i),
      .debug_serial_clock(ser_clk), .debug_serial_in_i(ser_in),
      .debug_serial_out_o(ser_out), .sup_wr_i(sup_wr_i), .sup_rd_i(sup_rd_i),
      .sup_idx_i(sup_idx_i), .sup_wdata_i(sup_wdata_i), .sup_rdata_o(sup_rdata_o),
      .bus_valid_i(bus_valid_i), .bus_addr_i(bus_addr_i), .bus_data_i(bus_data_i),
      .pc_valid_i(pc_valid_i), .pc_i(pc_i), .core_halted_i(core_halted_i),
      .branch_i(branch_i), .branch_tgt_i(branch_tgt_i), .crit_irq_i(crit_irq_i),
      .halt_req_o(halt_req_o), .dbg_irq_o(dbg_irq_o), .crit_irq_o(crit_irq_o),
      .processor_status_out(processor_status_out),
      .trace_data_out(trace_data_out), .status_clock_out(status_clock_out),
      .all_status_and_out(all_status_and_out));
   cdtt_dbg_tool cdtt_dbg_tool_i (.debug_serial_clock(ser_clk),
      .debug_serial_in_o(ser_in), .debug_serial_out_i(ser_out));

   always #50 core_clk_i = ~core_clk_i;

   task automatic wrap_up();
      $display("checks=%0d failures=%0d", checks, failures);
      if (failures == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   always @(posedge core_clk_i) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         wrap_up();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   function automatic logic [31:0] trg();
      return {30'h0, halt_req_o, dbg_irq_o};
   endfunction
   task automatic sup_wr(input logic [3:0] idx, input logic [31:0] d);
      @(negedge core_clk_i);
      sup_wr_i = 1'b1;
      sup_idx_i = idx;
      sup_wdata_i = d;
      @(negedge core_clk_i);
      sup_wr_i = 1'b0;
   endtask
   task automatic sup_rd(input logic [3:0] idx, output logic [31:0] d);
      @(negedge core_clk_i);
      sup_rd_i = 1'b1;
      sup_idx_i = idx;
      @(negedge core_clk_i);
      sup_rd_i = 1'b0;
      @(negedge core_clk_i);
      d = sup_rdata_o;
   endtask
   task automatic arm(input logic [31:0] ctrl);
      sup_wr(`CDTT_IDX_CTRL, 32'h0);
      sup_wr(`CDTT_IDX_CTRL, ctrl);
   endtask
   // One cycle of core activity, then settle before looking
   task automatic step(input logic bv, input logic [31:0] a, input logic [31:0] dt,
                       input logic pv, input logic [31:0] pc);
      @(negedge core_clk_i);
      bus_valid_i = bv;
      bus_addr_i = a;
      bus_data_i = dt;
      pc_valid_i = pv;
      pc_i = pc;
      @(negedge core_clk_i);
      bus_valid_i = 1'b0;
      pc_valid_i = 1'b0;
      @(negedge core_clk_i);
   endtask

   initial begin
      logic [31:0] v;
      int n;
      repeat (6) @(negedge core_clk_i);
      chk(trg(), 32'h0);
      chk(32'(processor_status_out), 32'h0);
      repeat (6) @(negedge core_clk_i);
      rstn_i = 1'b1;
      $display("test reset done");
      foreach (rows[i]) begin
         sup_wr(rows[i].idx, rows[i].wd);
         sup_rd(rows[i].idx, v);
         chk(v, rows[i].rd);
      end
      $display("test registers done");
      cdtt_dbg_tool_i.frame({`CDTT_OP_WR, `CDTT_IDX_ADDR, 32'hDEAD_BEEF}, v);
      sup_rd(`CDTT_IDX_ADDR, v);
      chk(v, 32'hDEAD_BEEF);
      sup_wr(`CDTT_IDX_DATA, 32'h0BAD_F00D);
      cdtt_dbg_tool_i.frame({`CDTT_OP_RD, `CDTT_IDX_DATA, 32'h0}, v);
      // Unknown opcode must change nothing; the read word comes out in
      // the frame after it, once the core side has fetched it
      cdtt_dbg_tool_i.frame({4'h3, `CDTT_IDX_DATA, 32'h1111_1111}, v);
      cdtt_dbg_tool_i.frame({4'h0, `CDTT_IDX_DATA, 32'h0}, v);
      chk(v, 32'h0BAD_F00D);
      sup_rd(`CDTT_IDX_DATA, v);
      chk(v, 32'h0BAD_F00D);
      $display("test serial done");
      sup_wr(`CDTT_IDX_PMSK, 32'h0);
      for (int k = 0; k < 4; k++) begin
         sup_wr(`CDTT_IDX_PC0 + 4'(k), 32'h100 + 32'(4 * k));
         arm(32'h25);
         step(1'b0, 32'h0, 32'h0, 1'b1, 32'h200);
         chk(trg(), 32'h0);
         step(1'b0, 32'h0, 32'h0, 1'b1, 32'h100 + 32'(4 * k));
         chk(trg(), 32'h2);
      end
      @(negedge core_clk_i);
      core_halted_i = 1'b1;
      repeat (2) @(negedge core_clk_i);
      chk(32'(processor_status_out), 32'hF);
      chk(32'(all_status_and_out), 32'h1);
      core_halted_i = 1'b0;
      repeat (2) @(negedge core_clk_i);
      chk(32'(all_status_and_out), 32'h0);
      $display("test halt done");
      #10;
      chk(32'(status_clock_out), 32'h0);
      #50;
      chk(32'(status_clock_out), 32'h1);
      sup_wr(`CDTT_IDX_ADDR, 32'h0000_4000);
      sup_wr(`CDTT_IDX_AMSK, 32'h0000_00FF);
      arm(32'h09);
      step(1'b1, 32'h0000_41AB, 32'h0, 1'b0, 32'h0);
      chk(trg(), 32'h0);
      step(1'b1, 32'h0000_40AB, 32'h0, 1'b0, 32'h0);
      chk(trg(), 32'h1);
      crit_irq_i = 1'b1;
      @(negedge core_clk_i);
      chk(32'(crit_irq_o), 32'h1);
      chk(trg(), 32'h1);
      crit_irq_i = 1'b0;
      @(negedge core_clk_i);
      chk(32'(crit_irq_o), 32'h0);
      ce_i = 1'b0;
      crit_irq_i = 1'b1;
      @(negedge core_clk_i);
      chk(32'(crit_irq_o), 32'h0);
      ce_i = 1'b1;
      crit_irq_i = 1'b0;
      // Full mask matches any address; a fired trigger stands
      sup_wr(`CDTT_IDX_AMSK, 32'hFFFF_FFFF);
      step(1'b1, 32'h1357_9BDF, 32'h0, 1'b0, 32'h0);
      chk(trg(), 32'h1);
      $display("test mask and interrupt done");
      sup_wr(`CDTT_IDX_DATA, 32'hCAFE_0000);
      sup_wr(`CDTT_IDX_DMSK, 32'h0000_FFFF);
      arm(32'h117);
      step(1'b0, 32'h0, 32'h0, 1'b1, 32'h100);
      chk(trg(), 32'h0);
      step(1'b1, 32'h0, 32'hCAFE_1234, 1'b0, 32'h0);
      chk(trg(), 32'h0);
      step(1'b0, 32'h0, 32'h0, 1'b1, 32'h100);
      chk(trg(), 32'h2);
      $display("test two level done");
      v = 32'h1234_ABCD;
      @(negedge core_clk_i);
      branch_i = 1'b1;
      branch_tgt_i = v;
      @(negedge core_clk_i);
      branch_i = 1'b0;
      n = 0;
      while (processor_status_out !== `CDTT_PST_BRANCH && n < 10) begin
         @(negedge core_clk_i);
         n++;
      end
      chk(32'(processor_status_out), 32'h5);
      for (int j = 0; j < 8; j++) begin
         @(negedge core_clk_i);
         chk(32'(processor_status_out), 32'h8);
         chk(32'(trace_data_out), 32'(v[4 * j +: 4]));
         chk(32'(all_status_and_out), 32'h0);
      end
      $display("test trace done");
      n = 0;
      @(negedge core_clk_i);
      branch_i = 1'b1;
      // The first word leaves while the burst is still arriving
      for (int j = 0; j < 10; j++) begin
         branch_tgt_i = 32'(j);
         @(negedge core_clk_i);
         if (processor_status_out === `CDTT_PST_BRANCH) n++;
      end
      branch_i = 1'b0;
      repeat (120) begin
         @(negedge core_clk_i);
         if (processor_status_out === `CDTT_PST_BRANCH) n++;
      end
      chk(32'(n), 32'h9);
      $display("test buffer full done");
      @(negedge core_clk_i);
      rstn_i = 1'b0;
      @(negedge core_clk_i);
      chk(trg(), 32'h0);
      chk(32'(processor_status_out), 32'h0);
      rstn_i = 1'b1;
      sup_rd(`CDTT_IDX_CTRL, v);
      chk(v, 32'h0);
      $display("test second reset done");
      wrap_up();
   end
endmodule
`default_nettype wire
